// ### dv/ess_engine_model.sv
module ess_engine_model (
  input wire hclk, // clock
  input wire hresetn, // reset
  input wire fuel_on, // fuel relay
  input wire will_fire, // engine catches
  input wire [15:0] load_req, // load offered
  output logic [15:0] speed_rpm, // pickup speed
  output logic [15:0] load_level // measured load
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] speed_ff;
  assign speed_rpm = speed_ff;
  assign load_level = fuel_on ? load_req : 16'h0000;
  // Ramps to 1200 rpm while fueled and firing, stops dead without fuel or firing
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) speed_ff <= 16'h0000;
    else if (!fuel_on || !will_fire) speed_ff <= 16'h0000;
    else if (speed_ff < 16'h04B0) speed_ff <= speed_ff + 16'h0032;
  end
endmodule

// ### dv/ess_seq_bench.sv
module ess_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, start_pin = 1'b0, stop_pin = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata_ff, d;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, fail_action_ff;
  logic [15:0] speed_rpm, load_level, load_req = 16'h0;
  logic hreadyout_ff, hresp_ff, glow_ff, crank_ff, fuel_ff, speed_relay_ff;
  logic crank_fail_ff, irq_ff, will_fire = 1'b1;
  int error_cnt = 0, checks_done = 0, n;
  logic [31:0] rows [17][2] = '{'{32'h00, 32'h5}, '{32'h04, 32'h0}, '{32'h08, 32'h2},
    '{32'h0C, 32'h64}, '{32'h10, 32'h1E}, '{32'h14, 32'h12C}, '{32'h18, 32'hC8},
    '{32'h1C, 32'h96}, '{32'h20, 32'h226}, '{32'h24, 32'h4B0}, '{32'h28, 32'h14},
    '{32'h2C, 32'h3}, '{32'h30, 32'h5}, '{32'h34, 32'h0}, '{32'h38, 32'h0},
    '{32'h3C, 32'h0}, '{32'h40, 32'h0}};

  always #12.5 hclk = ~hclk;

  ess_seq #(.TICK_CYCLES(T)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .hrdata_ff(hrdata_ff), .start_pin(start_pin), .stop_pin(stop_pin),
    .speed_rpm(speed_rpm), .load_level(load_level), .glow_ff(glow_ff),
    .crank_ff(crank_ff), .fuel_ff(fuel_ff), .speed_relay_ff(speed_relay_ff),
    .crank_fail_ff(crank_fail_ff), .fail_action_ff(fail_action_ff), .irq_ff(irq_ff));
  ess_engine_model eng (.hclk(hclk), .hresetn(hresetn), .fuel_on(fuel_ff),
    .will_fire(will_fire), .load_req(load_req), .speed_rpm(speed_rpm),
    .load_level(load_level));

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(string nm, int lo, int hi);
    chk(nm, 1, n >= lo && n <= hi);
  endtask
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout_ff !== 1'b1 && k < 20);
    chk("hready", 1, hreadyout_ff);
  endtask
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    d = hrdata_ff;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e, string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, d);
  endtask
  function automatic logic sg(int i);
    logic [5:0] v;
    v = {irq_ff, crank_fail_ff, speed_relay_ff, fuel_ff, crank_ff, glow_ff};
    return v[i];
  endfunction
  task automatic wt(int i, logic v);
    n = 0;
    while (sg(i) !== v && n < 5000) begin
      @(posedge hclk);
      n++;
    end
    chk("output level", v, sg(i));
  endtask
  task automatic go(logic [15:0] ld);
    load_req <= ld;
    stop_pin <= 1'b0;
    repeat (4) @(posedge hclk);
    start_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    start_pin <= 1'b0;
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) rd(rows[i][0], rows[i][1], "reset value");
    xfer(1'b1, 32'h34, 32'hFFFF);
    rd(32'h34, 32'h0, "status read only");
    $display("Test registers done");
    // Interlocked start, relay wired normally closed
    for (int i = 0; i < 6; i++) xfer(1'b1, 4 * i + ((i == 0) ? 32'h3C : 0),
      (i == 0) ? 32'hF : (i == 1) ? 32'h3 : (i == 2) ? 32'h2 : (i == 3) ? 32'h28 :
      (i == 4) ? 32'h1E : 32'h0);
    xfer(1'b1, 32'h18, 32'h5);
    xfer(1'b1, 32'h1C, 32'h4);
    xfer(1'b1, 32'h00, 32'h7);
    go(16'h0064);
    wt(0, 1'b1);
    wt(1, 1'b1);
    rng("glow time", 2 * T + 2, 3 * T + 1);
    wt(2, 1'b1);
    rng("fuel delay", T + 2, 2 * T + 1);
    wt(1, 1'b0);
    chk("glow after crank", 0, glow_ff);
    chk("cutout speed", 1, speed_rpm >= 16'h0226);
    repeat (2) @(posedge hclk);
    chk("idle relay", 1, speed_relay_ff);
    while (speed_rpm < 16'h0438) @(posedge hclk);
    wt(3, 1'b0);
    rng("idle hold", 5 * T - 1, 6 * T + 3);
    @(posedge hclk);
    chk("rated irq", 1, irq_ff);
    rd(32'h38, 32'h1, "irq status");
    xfer(1'b1, 32'h38, 32'h1);
    rd(32'h38, 32'h0, "irq cleared");
    stop_pin <= 1'b1;
    wt(2, 1'b0);
    rng("cooldown", 4 * T, 5 * T + 4);
    rd(32'h38, 32'h8, "stop irq");
    $display("Test normal start done");
    // Sequencing off, cooldown at idle
    xfer(1'b1, 32'h00, 32'h0);
    go(16'h0064);
    wt(3, 1'b1);
    rng("direct rated", 0, 6);
    repeat (10 * T) @(posedge hclk);
    chk("no glow", 0, glow_ff);
    chk("no crank", 0, crank_ff);
    stop_pin <= 1'b1;
    wt(3, 1'b0);
    rng("cooldown idle", 0, 5);
    chk("cooling fuel", 1, fuel_ff);
    wt(2, 1'b0);
    rng("cooldown time", 4 * T - 2, 5 * T + 3);
    go(16'h0000);
    wt(3, 1'b1);
    stop_pin <= 1'b1;
    wt(2, 1'b0);
    rng("skip cooldown", 0, 6);
    $display("Test direct start done");
    // Engine never fires: one retry then failure
    will_fire <= 1'b0;
    xfer(1'b1, 32'h00, 32'h5);
    xfer(1'b1, 32'h10, 32'h3);
    xfer(1'b1, 32'h14, 32'h4);
    xfer(1'b1, 32'h2C, 32'h1);
    xfer(1'b1, 32'h30, 32'h3);
    go(16'h0000);
    wt(1, 1'b1);
    wt(1, 1'b0);
    rng("no speed stop", 2 * T + 2, 3 * T + 1);
    wt(1, 1'b1);
    rng("retry gap", 6 * T + 2, 7 * T + 1);
    wt(1, 1'b0);
    wt(4, 1'b1);
    rng("fail entry", 0, 4);
    chk("fail action", 3'h3, fail_action_ff);
    rd(32'h34, 32'h28, "attempts and state");
    rd(32'h38, 32'hF, "attempt and fail irq");
    stop_pin <= 1'b1;
    wt(4, 1'b0);
    $display("Test crank failure done");
    // Reset in mid-run drops the glow relay and restores the settings
    go(16'h0000);
    wt(0, 1'b1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("glow in reset", 0, glow_ff);
    hresetn <= 1'b1;
    rd(32'h2C, 32'h3, "repeats after reset");
    $display("Test mid-run reset done");
    finish_test();
  end
endmodule

// ### dv/ess_seq_properties.sv
module ess_seq_properties #(
  parameter TICK_CYCLES = 4
) (
  input wire hclk, // clock
  input wire hresetn, // reset
  input wire hsel, // select
  input wire [1:0] htrans, // type
  input wire hwrite, // write
  input wire hready, // ready in
  input wire hreadyout_ff, // ready out
  input wire hresp_ff, // response
  input wire [15:0] speed_rpm, // speed
  input wire glow_ff, // glow
  input wire crank_ff, // crank
  input wire fuel_ff, // fuel
  input wire speed_relay_ff, // rated
  input wire crank_fail_ff, // failed
  input wire [2:0] fail_action_ff // action
);
  localparam int CRANK_MAX = 102 * TICK_CYCLES;
  localparam int NOSP_MAX = 32 * TICK_CYCLES;
  int crank_cnt_ff;
  int nosp_cnt_ff;
  wire rd_req = hsel && hready && htrans[1] && !hwrite;
  wire wr_req = hsel && hready && htrans[1] && hwrite;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crank_cnt_ff <= 0;
      nosp_cnt_ff <= 0;
    end else begin
      crank_cnt_ff <= crank_ff ? crank_cnt_ff + 1 : 0;
      nosp_cnt_ff <= (crank_ff && speed_rpm == 16'h0000) ? nosp_cnt_ff + 1 : 0;
    end
  end
  sequence s_read_wait;
    !hreadyout_ff ##1 hreadyout_ff;
  endsequence
  sequence s_crank_start;
    !crank_ff ##1 crank_ff;
  endsequence
  a_glow_covers: assert property (crank_ff |-> glow_ff)
    else $error("crank without glow");
  a_glow_first: assert property (s_crank_start |-> $past(glow_ff))
    else $error("crank before glow");
  a_crank_bound: assert property (crank_cnt_ff <= CRANK_MAX)
    else $error("crank too long");
  a_nospeed_stop: assert property (nosp_cnt_ff <= NOSP_MAX)
    else $error("crank kept without speed");
  a_cutout_release: assert property (crank_ff && speed_rpm >= 16'h0226 |-> ##[1:2] !crank_ff)
    else $error("crank kept above cutout");
  a_fail_quiet: assert property (crank_fail_ff |-> !crank_ff && !glow_ff && !fuel_ff
    && fail_action_ff != 3'h0)
    else $error("failed state not quiet");
  a_fail_code: assert property (!crank_fail_ff |-> fail_action_ff == 3'h0)
    else $error("action code outside failure");
  a_crank_idle: assert property (crank_ff |-> !speed_relay_ff)
    else $error("speed relay during crank");
  a_read_wait: assert property (rd_req |=> s_read_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr_req |=> hreadyout_ff && !hresp_ff)
    else $error("write stalled");
endmodule

bind ess_seq ess_seq_properties #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .speed_rpm(speed_rpm),
  .glow_ff(glow_ff), .crank_ff(crank_ff), .fuel_ff(fuel_ff),
  .speed_relay_ff(speed_relay_ff), .crank_fail_ff(crank_fail_ff),
  .fail_action_ff(fail_action_ff));

// ### hw/ess_regs.vh
`ifndef ESS_REGS_VH
`define ESS_REGS_VH

// Byte offsets of the register words
`define ESS_OFS_CTRL 6'h00
`define ESS_OFS_GLOW_TIME 6'h04
`define ESS_OFS_FUEL_DLY 6'h08
`define ESS_OFS_CRANK_TIME 6'h0C
`define ESS_OFS_NOSPD_TIME 6'h10
`define ESS_OFS_RETRY_TIME 6'h14
`define ESS_OFS_IDLE_TIME 6'h18
`define ESS_OFS_COOL_TIME 6'h1C
`define ESS_OFS_CUTOUT_RPM 6'h20
`define ESS_OFS_IDLE_RPM 6'h24
`define ESS_OFS_COOL_LOAD 6'h28
`define ESS_OFS_REPEATS 6'h2C
`define ESS_OFS_FAIL_ACT 6'h30
`define ESS_OFS_STATUS 6'h34
`define ESS_OFS_IRQ_STAT 6'h38
`define ESS_OFS_IRQ_MASK 6'h3C

// Word indices of the settings array and the status and interrupt words
`define ESS_IDX_CTRL 4'h0
`define ESS_IDX_GLOW 4'h1
`define ESS_IDX_FUEL 4'h2
`define ESS_IDX_CRANK 4'h3
`define ESS_IDX_NOSPD 4'h4
`define ESS_IDX_RETRY 4'h5
`define ESS_IDX_IDLE 4'h6
`define ESS_IDX_COOL 4'h7
`define ESS_IDX_CUTOUT 4'h8
`define ESS_IDX_IDLERPM 4'h9
`define ESS_IDX_LOAD 4'hA
`define ESS_IDX_REPEATS 4'hB
`define ESS_IDX_FAILACT 4'hC
`define ESS_NUM_CFG 4'hD
`define ESS_IDX_STATUS 4'hD
`define ESS_IDX_ISTAT 4'hE
`define ESS_IDX_IMASK 4'hF

// Control word fields
`define ESS_CTRL_SEQ_EN 0
`define ESS_CTRL_RELAY_NC 1
`define ESS_CTRL_COOL_RATED 2

// Interrupt status fields
`define ESS_IRQ_RATED 0
`define ESS_IRQ_ATTEMPT 1
`define ESS_IRQ_FAIL 2
`define ESS_IRQ_STOPPED 3

// Reset values; times in tenths of a second
`define ESS_RST_CTRL 16'h0005
`define ESS_RST_GLOW 16'h0000
`define ESS_RST_FUEL 16'h0002
`define ESS_RST_CRANK 16'h0064
`define ESS_RST_NOSPD 16'h001E
`define ESS_RST_RETRY 16'h012C
`define ESS_RST_IDLE 16'h00C8
`define ESS_RST_COOL 16'h0096
`define ESS_RST_CUTOUT 16'h0226
`define ESS_RST_IDLERPM 16'h04B0
`define ESS_RST_LOAD 16'h0014
`define ESS_RST_REPEATS 16'h0003
`define ESS_RST_FAILACT 16'h0005

// Timer tick: clock rate and tick period
`define ESS_CLK_HZ 40000000
`define ESS_TICK_MS 100
`define ESS_TICK_CYCLES (`ESS_CLK_HZ / 1000 * `ESS_TICK_MS)

// Idle reached at nine tenths (PCT over DIV) of the idle setpoint
`define ESS_IDLE_PCT 20'h00009
`define ESS_IDLE_DIV 20'h0000A

`endif

// ### hw/ess_seq.v
// Contract
// [RULE1] Glow for the set time before cranking, and stay on until crank ends.
// [RULE2] Glow output never turns on while sequencing is disabled.
// [RULE3] Fuel relay energizes a set delay after the crank relay.
// [RULE4] Crank at most the engagement time; on expiry stop and use one attempt.
// [RULE5] Sequencing disabled: engagement time ignored, crank never asserted.
// [RULE6] Starter released once speed reaches the cutout speed.
// [RULE7] Wait the retry interval between consecutive start attempts.
// [RULE8] One first attempt plus the set number of repeats.
// [RULE9] All attempts used: take the configured failure action.
// [RULE10] No speed within the timeout after cranking starts: open crank relay.
// [RULE11] Idle reached when speed attains 90 percent of the idle setpoint.
// [RULE12] Hold idle for the hold time after idle reached, then go rated.
// [RULE13] Sequencing disabled: start goes straight to rated, skipping glow, crank, idle.
// [RULE14] Normally closed speed relay: energized at idle, released for rated.
// [RULE15] Stop after high load: run the cooldown time before shutting down.
// [RULE16] Remember load above threshold during the run; otherwise skip cooldown.
// [RULE17] During cooldown run at idle or rated per a bit, default rated.
// [RULE18] All timers count a common 0.1 s tick, cleared on reset and phase entry.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "ess_regs.vh"

module ess_seq #(
  parameter TICK_CYCLES = `ESS_TICK_CYCLES
) (
  input wire hclk,                // system clock, 40 MHz
  input wire hresetn,             // async reset, active low
  input wire hsel,                // slave select
  input wire [31:0] haddr,        // byte address
  input wire [1:0] htrans,        // transfer type
  input wire hwrite,              // write when high
  input wire [2:0] hsize,         // transfer size
  input wire [31:0] hwdata,       // write data
  input wire hready,              // bus ready
  output reg hreadyout_ff,        // slave ready
  output reg hresp_ff,            // always OKAY
  output reg [31:0] hrdata_ff,    // read data
  input wire start_pin,           // start command pin
  input wire stop_pin,            // stop command pin
  input wire [15:0] speed_rpm,    // measured speed, same clock
  input wire [15:0] load_level,   // measured load, same clock
  output reg glow_ff,             // glow plug relay
  output reg crank_ff,            // starter crank relay
  output reg fuel_ff,             // fuel solenoid relay
  output reg speed_relay_ff,      // idle/rated relay
  output reg crank_fail_ff,       // start attempts exhausted
  output reg [2:0] fail_action_ff,// failure action code
  output reg irq_ff               // interrupt, level high
);

  localparam ST_IDLE = 4'h0;
  localparam ST_GLOW = 4'h1;
  localparam ST_CRANK = 4'h2;
  localparam ST_REST = 4'h3;
  localparam ST_WARM = 4'h4;
  localparam ST_HOLD = 4'h5;
  localparam ST_RUN = 4'h6;
  localparam ST_COOL = 4'h7;
  localparam ST_FAIL = 4'h8;

  // Settings and bus state
  reg [15:0] cfg_ff [0:12];
  reg [3:0] irq_stat_ff;
  reg [3:0] irq_mask_ff;
  reg [5:0] addr_ff;
  reg addr_ok_ff;
  reg wr_pend_ff;
  reg rd_pend_ff;
  reg [31:0] rd_mux;
  integer i;

  // Sequencer state
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [15:0] timer_ff;
  reg [4:0] attempts_ff;
  reg [4:0] nxt_attempts;
  reg load_seen_ff;
  reg [3:0] ev;
  reg nxt_glow;
  reg nxt_crank;
  reg nxt_fuel;
  reg nxt_relay;
  reg nxt_fail;

  // Pin synchronisers and edge detect
  reg start_s1_ff;
  reg start_s2_ff;
  reg start_s3_ff;
  reg stop_s1_ff;
  reg stop_s2_ff;

  wire tick;
  wire seq_en;
  wire relay_nc;
  wire cool_rated;
  wire start_evt;
  wire stop_lvl;
  wire [19:0] speed_x;
  wire [19:0] idle_x;
  wire idle_reached;
  wire speed_seen;
  wire rated_cmd;
  wire running;
  wire addr_phase;
  wire [3:0] widx;
  wire [3:0] ridx;
  wire [3:0] w1c;

  function [15:0] dflt;
    input [3:0] idx;
    begin
      case (idx)
        `ESS_IDX_CTRL: dflt = `ESS_RST_CTRL;
        `ESS_IDX_GLOW: dflt = `ESS_RST_GLOW;
        `ESS_IDX_FUEL: dflt = `ESS_RST_FUEL;
        `ESS_IDX_CRANK: dflt = `ESS_RST_CRANK;
        `ESS_IDX_NOSPD: dflt = `ESS_RST_NOSPD;
        `ESS_IDX_RETRY: dflt = `ESS_RST_RETRY;
        `ESS_IDX_IDLE: dflt = `ESS_RST_IDLE;
        `ESS_IDX_COOL: dflt = `ESS_RST_COOL;
        `ESS_IDX_CUTOUT: dflt = `ESS_RST_CUTOUT;
        `ESS_IDX_IDLERPM: dflt = `ESS_RST_IDLERPM;
        `ESS_IDX_LOAD: dflt = `ESS_RST_LOAD;
        `ESS_IDX_REPEATS: dflt = `ESS_RST_REPEATS;
        `ESS_IDX_FAILACT: dflt = `ESS_RST_FAILACT;
        default: dflt = 16'h0000;
      endcase
    end
  endfunction

  ess_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick_ff(tick)
  );

  assign seq_en = cfg_ff[`ESS_IDX_CTRL][`ESS_CTRL_SEQ_EN];
  assign relay_nc = cfg_ff[`ESS_IDX_CTRL][`ESS_CTRL_RELAY_NC];
  assign cool_rated = cfg_ff[`ESS_IDX_CTRL][`ESS_CTRL_COOL_RATED];
  assign start_evt = start_s2_ff & ~start_s3_ff;
  assign stop_lvl = stop_s2_ff;
  assign speed_x = {4'h0, speed_rpm} * `ESS_IDLE_DIV;
  assign idle_x = {4'h0, cfg_ff[`ESS_IDX_IDLERPM]} * `ESS_IDLE_PCT;
  assign idle_reached = (speed_x >= idle_x); // [RULE11]
  assign speed_seen = (speed_rpm != 16'h0000);
  assign running = (state_ff == ST_WARM) | (state_ff == ST_HOLD) |
                   (state_ff == ST_RUN) | (state_ff == ST_COOL);

  // Pin inputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_s1_ff <= 1'b0;
      start_s2_ff <= 1'b0;
      start_s3_ff <= 1'b0;
      stop_s1_ff <= 1'b0;
      stop_s2_ff <= 1'b0;
    end else begin
      start_s1_ff <= start_pin;
      start_s2_ff <= start_s1_ff;
      start_s3_ff <= start_s2_ff;
      stop_s1_ff <= stop_pin;
      stop_s2_ff <= stop_s1_ff;
    end
  end

  // Sequencer next state
  always @* begin
    nxt_state = state_ff;
    nxt_attempts = attempts_ff;
    ev = 4'h0;
    case (state_ff)
      ST_IDLE: begin
        nxt_attempts = 5'h00;
        if (start_evt && !stop_lvl) begin
          nxt_state = seq_en ? ST_GLOW : ST_RUN; // [RULE13]
          if (!seq_en) begin
            ev[`ESS_IRQ_RATED] = 1'b1;
          end
        end
      end
      ST_GLOW: begin
        if (stop_lvl) begin
          nxt_state = ST_IDLE;
        end else if (timer_ff >= cfg_ff[`ESS_IDX_GLOW]) begin
          nxt_state = ST_CRANK; // [RULE1]
        end
      end
      ST_CRANK: begin
        if (stop_lvl) begin
          nxt_state = ST_IDLE;
        end else if (speed_rpm >= cfg_ff[`ESS_IDX_CUTOUT]) begin
          nxt_state = ST_WARM; // [RULE6]
        end else if ((timer_ff >= cfg_ff[`ESS_IDX_CRANK]) || // [RULE4]
                     (!speed_seen && timer_ff >= cfg_ff[`ESS_IDX_NOSPD])) begin // [RULE10]
          ev[`ESS_IRQ_ATTEMPT] = 1'b1;
          nxt_attempts = attempts_ff + 5'h01;
          if ({11'h000, attempts_ff} >= cfg_ff[`ESS_IDX_REPEATS]) begin // [RULE8]
            nxt_state = ST_FAIL; // [RULE9]
            ev[`ESS_IRQ_FAIL] = 1'b1;
          end else begin
            nxt_state = ST_REST;
          end
        end
      end
      ST_REST: begin
        if (stop_lvl) begin
          nxt_state = ST_IDLE;
        end else if (timer_ff >= cfg_ff[`ESS_IDX_RETRY]) begin
          nxt_state = ST_GLOW; // [RULE7]
        end
      end
      ST_WARM: begin
        if (idle_reached) begin
          nxt_state = ST_HOLD; // [RULE12]
        end
      end
      ST_HOLD: begin
        if (timer_ff >= cfg_ff[`ESS_IDX_IDLE]) begin
          nxt_state = ST_RUN; // [RULE12]
          ev[`ESS_IRQ_RATED] = 1'b1;
        end
      end
      ST_RUN: begin
      end
      ST_COOL: begin
        if (timer_ff >= cfg_ff[`ESS_IDX_COOL]) begin
          nxt_state = ST_IDLE; // [RULE15]
          ev[`ESS_IRQ_STOPPED] = 1'b1;
        end
      end
      ST_FAIL: begin
        if (stop_lvl) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Stop while the engine runs: cooldown only after high load
    if (running && state_ff != ST_COOL && stop_lvl) begin
      if (load_seen_ff) begin
        nxt_state = ST_COOL; // [RULE15]
      end else begin
        nxt_state = ST_IDLE; // [RULE16]
        ev[`ESS_IRQ_STOPPED] = 1'b1;
      end
    end
  end

  // Relay outputs follow the next state
  assign rated_cmd = (nxt_state == ST_RUN) |
                     ((nxt_state == ST_COOL) & cool_rated); // [RULE17]

  always @* begin
    nxt_glow = seq_en & ((nxt_state == ST_GLOW) | (nxt_state == ST_CRANK)); // [RULE1] [RULE2]
    nxt_crank = seq_en & (nxt_state == ST_CRANK); // [RULE5]
    nxt_fuel = fuel_ff;
    if (nxt_state == ST_CRANK) begin
      nxt_fuel = fuel_ff | (timer_ff >= cfg_ff[`ESS_IDX_FUEL]); // [RULE3]
      if (state_ff != ST_CRANK) begin
        nxt_fuel = (cfg_ff[`ESS_IDX_FUEL] == 16'h0000); // [RULE3]
      end
    end else if (nxt_state == ST_WARM || nxt_state == ST_HOLD ||
                 nxt_state == ST_RUN || nxt_state == ST_COOL) begin
      nxt_fuel = 1'b1;
    end else begin
      nxt_fuel = 1'b0;
    end
    if (relay_nc) begin
      nxt_relay = (nxt_state == ST_WARM || nxt_state == ST_HOLD || // [RULE14]
                   nxt_state == ST_COOL) & ~rated_cmd;
    end else begin
      nxt_relay = rated_cmd;
    end
    nxt_fail = (nxt_state == ST_FAIL);
  end

  // Sequencer registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ST_IDLE;
      timer_ff <= 16'h0000;
      attempts_ff <= 5'h00;
      load_seen_ff <= 1'b0;
      glow_ff <= 1'b0;
      crank_ff <= 1'b0;
      fuel_ff <= 1'b0;
      speed_relay_ff <= 1'b0;
      crank_fail_ff <= 1'b0;
      fail_action_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      attempts_ff <= nxt_attempts;
      if (nxt_state != state_ff) begin
        timer_ff <= 16'h0000; // [RULE18]
      end else if (tick && timer_ff != 16'hFFFF) begin
        timer_ff <= timer_ff + 16'h0001; // [RULE18]
      end
      if (state_ff == ST_IDLE) begin
        load_seen_ff <= 1'b0;
      end else if (running && load_level > cfg_ff[`ESS_IDX_LOAD]) begin
        load_seen_ff <= 1'b1; // [RULE16]
      end
      glow_ff <= nxt_glow;
      crank_ff <= nxt_crank;
      fuel_ff <= nxt_fuel;
      speed_relay_ff <= nxt_relay;
      crank_fail_ff <= nxt_fail;
      fail_action_ff <= nxt_fail ? cfg_ff[`ESS_IDX_FAILACT][2:0] : 3'h0; // [RULE9]
    end
  end

  // Bus slave: writes zero wait, reads one wait state
  assign addr_phase = hsel & hready & htrans[1];
  assign widx = addr_ff[5:2];
  assign ridx = addr_ff[5:2];
  assign w1c = (wr_pend_ff && addr_ok_ff && widx == `ESS_IDX_ISTAT) ? hwdata[3:0] : 4'h0;

  always @* begin
    rd_mux = 32'h00000000;
    if (addr_ok_ff) begin
      if (ridx < `ESS_NUM_CFG) begin
        rd_mux = {16'h0000, cfg_ff[ridx]};
      end else if (ridx == `ESS_IDX_STATUS) begin
        rd_mux = {22'h000000, load_seen_ff, attempts_ff, state_ff};
      end else if (ridx == `ESS_IDX_ISTAT) begin
        rd_mux = {28'h0000000, irq_stat_ff};
      end else begin
        rd_mux = {28'h0000000, irq_mask_ff};
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
      addr_ff <= 6'h00;
      addr_ok_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      irq_stat_ff <= 4'h0;
      irq_mask_ff <= 4'h0;
      irq_ff <= 1'b0;
      for (i = 0; i < 13; i = i + 1) begin
        cfg_ff[i] <= dflt(i[3:0]);
      end
    end else begin
      hresp_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      if (rd_pend_ff) begin
        hrdata_ff <= rd_mux;
        hreadyout_ff <= 1'b1;
        rd_pend_ff <= 1'b0;
      end else if (addr_phase) begin
        addr_ff <= haddr[5:0];
        addr_ok_ff <= (haddr[31:6] == 26'h0000000);
        wr_pend_ff <= hwrite;
        rd_pend_ff <= ~hwrite;
        hreadyout_ff <= hwrite;
      end
      if (wr_pend_ff && addr_ok_ff) begin
        if (widx < `ESS_NUM_CFG) begin
          cfg_ff[widx] <= hwdata[15:0];
        end else if (widx == `ESS_IDX_IMASK) begin
          irq_mask_ff <= hwdata[3:0];
        end
      end
      // Set wins over a same-cycle clear
      irq_stat_ff <= (irq_stat_ff & ~w1c) | ev;
      irq_ff <= |(((irq_stat_ff & ~w1c) | ev) & irq_mask_ff);
    end
  end

endmodule

// ### hw/ess_tick.v
module ess_tick #(
  parameter TICK_CYCLES = 4000000
) (
  input wire hclk,       // system clock
  input wire hresetn,    // async reset, active low
  output reg tick_ff     // one-cycle pulse per tick period
);

  reg [31:0] cnt_ff;
  wire wrap;

  assign wrap = (cnt_ff >= TICK_CYCLES - 1);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 32'h00000000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= wrap ? 32'h00000000 : cnt_ff + 32'h00000001;
      tick_ff <= wrap;
    end
  end

endmodule
